// ==== dac_output_gain_regs.sv ====
// AHB-Lite register bank holding converter output gain and mute controls.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
module dac_output_gain_regs (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        reset_pin_n_in,
  input  wire logic        powerdown_pin_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic      [3:0]  mute_out,
  output logic      [5:0]  analog_code_out [4],
  output logic      [5:0]  digital_code_out [4]
);
  // ****************************************************************************
  // Pin synchronisers
  // ****************************************************************************
  logic [1:0]  rst_sync_q;
  logic [1:0]  rst_sync_d;
  logic [1:0]  pd_sync_q;
  logic [1:0]  pd_sync_d;
  // Both stages clear in reset, so the pins count as asserted until two edges
  // after release; the gain registers stay at default for that long.
  always_comb begin
    rst_sync_d = {rst_sync_q[0], reset_pin_n_in};
    pd_sync_d  = {pd_sync_q[0], powerdown_pin_n_in};
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rst_sync_q <= 2'h0;
      pd_sync_q  <= 2'h0;
    end else begin
      rst_sync_q <= rst_sync_d;
      pd_sync_q  <= pd_sync_d;
    end
  end

  // ****************************************************************************
  // Bus address phase capture
  // ****************************************************************************
  logic        wr_pend_q;
  logic        wr_pend_d;
  logic        rd_pend_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic        take;
  // Only whole-word transfers are decoded; narrower ones answer OKAY and change nothing.
  // The address is kept because the write data arrive one cycle after it.
  always_comb begin
    take      = hsel_in && hready_in && (htrans_in == gain_regs_pkg::HTRANS_NONSEQ)
                && (hsize_in == gain_regs_pkg::HSIZE_WORD);
    wr_pend_d = take && hwrite_in;
    rd_pend_d = take && !hwrite_in;
    addr_d    = take ? haddr_in : addr_q;
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 32'h0;
    end else begin
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
    end
  end

  // ****************************************************************************
  // Registers
  // ****************************************************************************
  // The control word keeps only the power-down and enable bits that this bank obeys.
  logic [3:0]  ctrl_q;
  logic [3:0]  ctrl_d;
  logic [15:0] conv1_q;
  logic [15:0] conv1_d;
  logic [15:0] conv2_q;
  logic [15:0] conv2_d;
  logic        wr_ctrl;
  logic        wr_conv1;
  logic        wr_conv2;
  logic        common_hold;
  logic        conv1_hold;
  logic        conv2_hold;
  always_comb begin
    wr_ctrl     = wr_pend_q && (addr_q == gain_regs_pkg::CONTROL_ADDR);
    wr_conv1    = wr_pend_q && (addr_q == gain_regs_pkg::CONV1_GAIN_ADDR);
    wr_conv2    = wr_pend_q && (addr_q == gain_regs_pkg::CONV2_GAIN_ADDR);
    // Common hold conditions follow the reset pin, power-down pin and global bit.
    common_hold = !rst_sync_q[1] || !pd_sync_q[1]
                  || ctrl_q[gain_regs_pkg::GLOBAL_PD_BIT]; // [RULE_05]
    conv1_hold  = common_hold || !ctrl_q[gain_regs_pkg::ANALOG_EN_BIT]
                  || !ctrl_q[gain_regs_pkg::CONV1_EN_BIT]; // [RULE_06]
    // The second converter also loses its setting when the analog channels power down.
    conv2_hold  = common_hold || !ctrl_q[gain_regs_pkg::ANALOG_EN_BIT]
                  || !ctrl_q[gain_regs_pkg::CONV2_EN_BIT]; // [RULE_09]
  end
  always_comb begin
    ctrl_d  = ctrl_q;
    conv1_d = conv1_q;
    conv2_d = conv2_q;
    if (wr_ctrl) begin
      ctrl_d = hwdata_in[3:0];
    end
    // Reserved bits are stored as written; software keeps them zero.
    if (wr_conv1) begin
      conv1_d = hwdata_in[15:0]; // [RULE_07]
    end
    if (wr_conv2) begin
      conv2_d = hwdata_in[15:0]; // [RULE_08]
    end
    // A hold wins over a write in the same cycle, so a held register reads default.
    if (conv1_hold) begin
      conv1_d = gain_regs_pkg::CONV1_GAIN_RESET; // [RULE_04] [RULE_06]
    end
    if (conv2_hold) begin
      conv2_d = gain_regs_pkg::CONV2_GAIN_RESET; // [RULE_09]
    end
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_q  <= gain_regs_pkg::CONTROL_RESET;
      conv1_q <= gain_regs_pkg::CONV1_GAIN_RESET; // [RULE_04]
      conv2_q <= gain_regs_pkg::CONV2_GAIN_RESET;
    end else begin
      ctrl_q  <= ctrl_d;
      conv1_q <= conv1_d;
      conv2_q <= conv2_d;
    end
  end

  // ****************************************************************************
  // Read data
  // ****************************************************************************
  logic [31:0] rdata_d;
  // Read data come from the next-state values, so a read that directly follows a
  // write to the same register already returns the new word.
  always_comb begin
    rdata_d = 32'h0;
    if (rd_pend_d) begin
      unique case (haddr_in)
        gain_regs_pkg::CONV1_GAIN_ADDR: rdata_d = {16'h0, conv1_d}; // [RULE_10]
        gain_regs_pkg::CONV2_GAIN_ADDR: rdata_d = {16'h0, conv2_d}; // [RULE_10]
        gain_regs_pkg::CONTROL_ADDR:    rdata_d = {28'h0, ctrl_d};
        default:                        rdata_d = 32'h0;
      endcase
    end
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hrdata_out <= 32'h0;
    end else begin
      hrdata_out <= rdata_d;
    end
  end

  // ****************************************************************************
  // Gain split into analog and digital stages, per channel
  // ****************************************************************************
  // Channel order: 0 left conv1, 1 right conv1, 2 left conv2, 3 right conv2.
  logic [15:0] chan_reg [4];
  logic [5:0]  ana_d [4];
  logic [5:0]  dig_d [4];
  logic [3:0]  mute_d;
  // Both channels of a converter read the same register word.
  assign chan_reg[0] = conv1_d;
  assign chan_reg[1] = conv1_d;
  assign chan_reg[2] = conv2_d;
  assign chan_reg[3] = conv2_d;
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      localparam int MB = (ch % 2 == 0) ? gain_regs_pkg::LEFT_MUTE_BIT
                                        : gain_regs_pkg::RIGHT_MUTE_BIT;
      localparam int GL = (ch % 2 == 0) ? gain_regs_pkg::LEFT_GAIN_LSB
                                        : gain_regs_pkg::RIGHT_GAIN_LSB;
      logic [5:0] code;
      always_comb begin
        code       = chan_reg[ch][GL +: gain_regs_pkg::GAIN_W];
        // A muted channel keeps its gain code, so unmuting restores the level at once.
        mute_d[ch] = chan_reg[ch][MB]; // [RULE_01]
        // Analog code counts 1.5 dB steps below +12 dB; 8 is unity. [RULE_02]
        // Codes past the analog floor need up to 32 digital steps, so the
        // digital step count is six bits wide.
        if ((code & gain_regs_pkg::DIGITAL_FLAG) != 6'h0) begin
          ana_d[ch] = gain_regs_pkg::ANALOG_MAX_CODE; // [RULE_03]
          dig_d[ch] = {1'b0, code[4:0]} + 6'h01;      // [RULE_03]
        end else begin
          ana_d[ch] = code;
          dig_d[ch] = 6'h00;
        end
      end
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          mute_out[ch]         <= 1'b1;
          analog_code_out[ch]  <= 6'h08;
          digital_code_out[ch] <= 6'h00;
        end else begin
          mute_out[ch]         <= mute_d[ch];
          analog_code_out[ch]  <= ana_d[ch];
          digital_code_out[ch] <= dig_d[ch];
        end
      end
    end
  endgenerate

  // ****************************************************************************
  // Bus response
  // ****************************************************************************
  // Every register answers from its next-state value within the address-phase cycle, so the
  // slave never needs a wait state and never reports an error.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end
endmodule : dac_output_gain_regs

// ==== dac_output_gain_regs_tb.sv ====
// Testbench for the converter gain and mute register bank.
`timescale 1ns/10ps
module dac_output_gain_regs_tb;
  localparam logic [31:0] A1 = gain_regs_pkg::CONV1_GAIN_ADDR;
  localparam logic [31:0] A2 = gain_regs_pkg::CONV2_GAIN_ADDR;
  localparam logic [31:0] AC = gain_regs_pkg::CONTROL_ADDR;
  logic        mclk_in, reset_in, reset_pin_n_in, powerdown_pin_n_in, hsel_in, hwrite_in, hready;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [3:0]  mute_out;
  logic [5:0]  ana [4];
  logic [5:0]  dig [4];
  int          n_fail, cmp_count, cyc;
  dac_output_gain_regs dac_output_gain_regs_i (.mclk_in, .reset_in, .reset_pin_n_in,
    .powerdown_pin_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
    .hready_in(hready), .hrdata_out, .hreadyout_out(hready), .hresp_out(), .mute_out,
    .analog_code_out(ana), .digital_code_out(dig));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic test_done;
    $display("compares=%0d failures=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // The answer has no wait states today, yet both phases still wait on ready.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge mclk_in);
    haddr_in  <= a;
    hwrite_in <= wr;
    htrans_in <= gain_regs_pkg::HTRANS_NONSEQ;
    do @(posedge mclk_in); while (hready !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hready !== 1'b1);
    rd = hrdata_out;
  endtask : xfer
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic t_fields;
    rchk(A1, 32'h8888);
    xfer(1'b1, 32'h30, 32'h1234);
    rchk(32'h30, 32'h0);
    xfer(1'b1, A1, 32'h3f25);
    xfer(1'b1, A2, 32'h8a00);
    rchk(A1, 32'h3f25);
    rchk(A2, 32'h8a00);
    chk({28'h0, mute_out}, 32'h4);
    chk({8'h0, ana[0], ana[1], ana[2], ana[3]}, {8'h0, 6'h1f, 6'h1f, 6'h0a, 6'h00});
    chk({26'h0, dig[1]}, 32'h6);
    chk({26'h0, dig[0]}, 32'h20);
  endtask : t_fields
  task automatic t_hold;
    logic [3:0] c [6];
    logic [5:0] ok1;
    logic [5:0] ok2;
    c   = '{4'h8, 4'h6, 4'hf, 4'ha, 4'hc, 4'he};
    ok1 = 6'b100010;
    ok2 = 6'b101000;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, AC, {28'h0, c[i]});
      xfer(1'b1, A1, 32'h0101);
      xfer(1'b1, A2, 32'h0101);
      rchk(A1, ok1[i] ? 32'h0101 : 32'h8888);
      rchk(A2, ok2[i] ? 32'h0101 : 32'h8888);
    end
    xfer(1'b1, AC, 32'he);
    for (int j = 0; j < 2; j++) begin
      xfer(1'b1, A1, 32'h0101);
      rchk(A1, 32'h0101);
      {reset_pin_n_in, powerdown_pin_n_in} <= j ? 2'b10 : 2'b01;
      repeat (8) @(posedge mclk_in);
      xfer(1'b1, A1, 32'h0202);
      rchk(A1, 32'h8888);
      {reset_pin_n_in, powerdown_pin_n_in} <= 2'b11;
      repeat (4) @(posedge mclk_in);
    end
  endtask : t_hold
  initial begin
    {reset_in, reset_pin_n_in, powerdown_pin_n_in, hsel_in, hwrite_in} = 5'b11110;
    {haddr_in, hwdata_in, htrans_in, hsize_in} = {64'h0, 2'h0, 3'h2};
    {n_fail, cmp_count, cyc} = '0;
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_fields();
    t_hold();
    test_done();
  end
endmodule : dac_output_gain_regs_tb

// ==== gain_regs_chk.sv ====
// Checker of bus answers, hold conditions and the analog/digital gain split.
`timescale 1ns/10ps
module gain_regs_chk (
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        reset_pin_n_in,
  input wire logic        powerdown_pin_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [3:0]  mute_out,
  input wire logic [5:0]  analog_code_out [4],
  input wire logic [5:0]  digital_code_out [4]
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic rd_take;
  assign rd_take = hsel_in & hready_in & ~hwrite_in & (htrans_in == gain_regs_pkg::HTRANS_NONSEQ);
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("bad response");
  a_ready_high: assert property (hreadyout_out == 1'b1) else $error("wait state");
  a_rdata_idle: assert property (!$past(rd_take) |-> hrdata_out == 32'h0)
    else $error("read data outside data phase");
  a_rdata_upper: assert property (rd_take |=> hrdata_out[31:16] == 16'h0)
    else $error("upper read bits set");
  a_split_left: assert property (digital_code_out[0] != 6'h00 |-> analog_code_out[0] == 6'h1f)
    else $error("digital step before analog floor");
  a_split_right: assert property (digital_code_out[1] != 6'h00 |-> analog_code_out[1] == 6'h1f)
    else $error("digital step before analog floor");
  // Six cycles cover the pin synchroniser and the output register.
  a_pin_mute: assert property (!reset_pin_n_in [*6] |-> mute_out == 4'hf)
    else $error("reset pin low but not muted");
  a_pd_unity: assert property (!powerdown_pin_n_in [*6] |-> analog_code_out[0] == 6'h08)
    else $error("power-down pin low but gain not default");
  c_unmuted: cover property (mute_out == 4'h0);
  c_digital: cover property (digital_code_out[1] != 6'h00);
  c_read: cover property (rd_take);
  c_deepest: cover property (digital_code_out[0] == 6'h20);
endmodule : gain_regs_chk
bind dac_output_gain_regs gain_regs_chk gain_regs_chk_i (.mclk_in, .reset_in, .reset_pin_n_in,
  .powerdown_pin_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
  .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .mute_out, .analog_code_out,
  .digital_code_out);

// ==== gain_regs_pkg.sv ====
// Package with register map, field layout, reset values and gain-stage constants.
// ****************************************************************************
// Behaviour
// RULE_01: Mute bit one mutes channel, zero enables.
// RULE_02: Gain code steps 1.5 dB, code 8 unity.
// RULE_03: Top bit clear analog only; set adds digital.
// RULE_04: First converter register resets to 0x8888.
// RULE_05: Reset, power-down pin or global power-down force default.
// RULE_06: First register also held by analog/conv1 enable low.
// RULE_07: Software writes zero to reserved bits 14, 6.
// RULE_08: Second register fields: mute, reserved, gain code.
// RULE_09: Second register also held by analog/conv2 enable low.
// RULE_10: Reads return held fields, reserved as written.
// ****************************************************************************
package gain_regs_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0]  CONV1_GAIN_IDX   = 8'h09;
  localparam logic [7:0]  CONV2_GAIN_IDX   = 8'h0a;
  localparam logic [7:0]  CONTROL_IDX      = 8'h1b;
  localparam logic [31:0] CONV1_GAIN_ADDR  = {22'h0, CONV1_GAIN_IDX, 2'h0};
  localparam logic [31:0] CONV2_GAIN_ADDR  = {22'h0, CONV2_GAIN_IDX, 2'h0};
  localparam logic [31:0] CONTROL_ADDR     = {22'h0, CONTROL_IDX, 2'h0};
  localparam logic [15:0] CONV1_GAIN_RESET = 16'h8888;
  localparam logic [15:0] CONV2_GAIN_RESET = 16'h8888;
  // Control bits of the block's own control register.
  localparam int          GLOBAL_PD_BIT    = 0;
  localparam int          ANALOG_EN_BIT    = 1;
  localparam int          CONV1_EN_BIT     = 2;
  localparam int          CONV2_EN_BIT     = 3;
  localparam logic [3:0]  CONTROL_RESET    = 4'he;
  // Field layout.
  localparam int          LEFT_MUTE_BIT    = 15;
  localparam int          LEFT_GAIN_LSB    = 8;
  localparam int          RIGHT_MUTE_BIT   = 7;
  localparam int          RIGHT_GAIN_LSB   = 0;
  localparam int          GAIN_W           = 6;
  // Gain stage: analog part saturates at this code, beyond it digital steps.
  localparam logic [5:0]  ANALOG_MAX_CODE  = 6'h1f;
  localparam logic [5:0]  DIGITAL_FLAG     = 6'h20;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
endpackage : gain_regs_pkg
